// [shared/jtl_params.svh]
// constants for the jesd transmit link configuration block
`ifndef JTL_PARAMS_SVH
`define JTL_PARAMS_SVH

`define JTL_IDX_MF_SETUP   6'h03
`define JTL_IDX_SCR_CTRL   6'h05
`define JTL_IDX_MF_LEN     6'h06
`define JTL_IDX_LANE_SWAP  6'h21
`define JTL_IDX_POLARITY   6'h22
`define JTL_IDX_STATUS     6'h24

`define JTL_RST_BYTE       8'h00
`define JTL_RST_SCR        15'h0000

`define JTL_PRESET_BIT     7
`define JTL_START_HI       6
`define JTL_START_LO       2
`define JTL_DELAY_HI       1
`define JTL_DELAY_LO       0
`define JTL_SCR_BIT        7
`define JTL_K_HI           4
`define JTL_K_LO           0
`define JTL_POL_HI         3
`define JTL_POL_LO         0
`define JTL_STAT_CNT_HI    4
`define JTL_STAT_CNT_LO    0

`define JTL_SEL_SWAP       2'b10
`define JTL_LMFC_LAST      5'h1F
`define JTL_ILA_LAST       2'h3

`define JTL_K28_5          8'hBC
`define JTL_K28_0          8'h1C
`define JTL_K28_3          8'h7C
`define JTL_FILL           8'h00

`endif

// [shared/jtl_pkg.sv]
// types shared by the jesd transmit link configuration block
package jtl_pkg;

  typedef enum logic [2:0] {
    JTL_CGS,
    JTL_WAIT_LMFC,
    JTL_DELAY,
    JTL_ILA,
    JTL_DATA
  } jtl_state_t;

  typedef logic [3:0][7:0] jtl_octets_t;

endpackage : jtl_pkg

// [hdl/jtl_lmfc.sv]
// local multiframe counter and frame-in-multiframe counter
`timescale 1ns/1ns
`default_nettype none
module jtl_lmfc
  import jtl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sysref_i,
  input  wire logic       preset_en_i,
  input  wire logic [4:0] start_val_i,
  input  wire logic [4:0] k_field_i,
  output logic      [4:0] lmfc_cnt_o,
  output logic            mf_start_o,
  output logic            frame_last_o
);

  typedef struct packed {
    logic [4:0] cnt;
    logic [4:0] frame;
    logic       mf_start;
  } jtl_lmfc_st_t;

  jtl_lmfc_st_t q;
  jtl_lmfc_st_t n;

  always_comb
  begin
    n = q;
    if (sysref_i)
    begin
      n.cnt      = preset_en_i ? start_val_i : 5'h00; // R1 R2 R4
      n.frame    = 5'h00;
      n.mf_start = 1'b0;
    end
    else
    begin
      n.cnt      = q.cnt + 5'h01;
      n.mf_start = (q.frame == k_field_i);
      // frames per multiframe is field plus one
      n.frame    = (q.frame == k_field_i) ? 5'h00 : q.frame + 5'h01; // R7
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end

  assign lmfc_cnt_o   = q.cnt;
  assign mf_start_o   = q.mf_start;
  assign frame_last_o = (q.frame == k_field_i);

endmodule : jtl_lmfc
`default_nettype wire

// [hdl/jtl_lane_map.sv]
// channel to lane steering with per-channel polarity flags
`timescale 1ns/1ns
`default_nettype none
`include "jtl_params.svh"
module jtl_lane_map
  import jtl_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire jtl_pkg::jtl_octets_t ch_dat_i,
  input  wire logic        [3:0] ch_k_i,
  input  wire logic        [7:0] lane_sel_i,
  input  wire logic        [3:0] pol_i,
  output var jtl_pkg::jtl_octets_t lane_dat_o,
  output logic             [3:0] lane_k_o,
  output logic             [3:0] lane_inv_o
);

  typedef struct packed {
    jtl_octets_t dat;
    logic [3:0]  k;
    logic [3:0]  inv;
  } jtl_lane_st_t;

  jtl_lane_st_t q;
  jtl_lane_st_t n;
  logic [3:0][1:0] src;
  logic [3:0]   ch_inv;
  logic [1:0]   sel_a;
  logic [1:0]   sel_b;
  logic [1:0]   sel_c;
  logic [1:0]   sel_d;

  assign sel_a = lane_sel_i[7:6];
  assign sel_b = lane_sel_i[5:4];
  assign sel_c = lane_sel_i[3:2];
  assign sel_d = lane_sel_i[1:0];
  // channel index 0..3 is a..d, polarity bit 3 is channel a
  assign ch_inv = {pol_i[0], pol_i[1], pol_i[2], pol_i[3]}; // R14

  // source channel of each lane; each lane takes the other channel of its pair when that channel's select code is 10
  always_comb
  begin
    n      = q;
    src[0] = (sel_b == `JTL_SEL_SWAP) ? 2'h1 : 2'h0; // R8 R9
    src[1] = (sel_a == `JTL_SEL_SWAP) ? 2'h0 : 2'h1; // R8 R9
    src[2] = (sel_d == `JTL_SEL_SWAP) ? 2'h3 : 2'h2; // R10 R11
    src[3] = (sel_c == `JTL_SEL_SWAP) ? 2'h2 : 2'h3; // R10 R11
    for (int l = 0; l < 4; l++)
    begin
      n.dat[l] = ch_dat_i[src[l]];
      n.k[l]   = ch_k_i[src[l]];
      n.inv[l] = ch_inv[src[l]]; // R14
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= n;
  end

  assign lane_dat_o = q.dat;
  assign lane_k_o   = q.k;
  assign lane_inv_o = q.inv;

endmodule : jtl_lane_map
`default_nettype wire

// [hdl/jtl_link_cfg.sv]
// jesd transmit link configuration, sequencing and wishbone registers
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "jtl_params.svh"

//Contract
// (R1) preset bit loads start value, else zero
// (R2) sysref resets local multiframe counter
// (R3) stop K28.5 when counter reaches 31
// (R4) start value field bits 6..2 used
// (R5) delay alignment sequence 0..3 multiframes
// (R6) scramble lane data when bit 7 set
// (R7) frames per multiframe is field plus one
// (R8) channel A on lane one, swap to two
// (R9) channel B on lane two, swap to one
// (R10) channel C on lane three, swap to four
// (R11) channel D on lane four, swap to three
// (R12) software never writes select codes 01, 11
// (R13) swapping only allowed in four-lane mode
// (R14) polarity bits 3..0 invert channels A..D
// (R15) only polarity codes 0000,0011,1100,1111 allowed
// (R16) all configuration zero after reset
module jtl_link_cfg
  import jtl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sysref_i,
  input  wire logic        sync_n_i,
  input  wire logic [7:0]  chan_a_i,
  input  wire logic [7:0]  chan_b_i,
  input  wire logic [7:0]  chan_c_i,
  input  wire logic [7:0]  chan_d_i,
  output logic      [7:0]  lane_one_o,
  output logic      [7:0]  lane_two_o,
  output logic      [7:0]  lane_three_o,
  output logic      [7:0]  lane_four_o,
  output logic      [3:0]  lane_k_o,
  output logic      [3:0]  lane_inv_o
);

  import jtl_pkg::*;

  typedef struct packed {
    logic              ack;
    logic [7:0]        rdat;
    logic              counter_preset_enable;
    logic [4:0]        counter_start_value;
    logic [1:0]        alignment_seq_delay;
    logic              scramble_enable;
    logic [4:0]        frames_field;
    logic [7:0]        lane_select;
    logic [3:0]        polarity_flip;
    logic              sysref_meta;
    logic              sysref_sync;
    logic              sysref_prev;
    logic              sync_n_meta;
    logic              sync_n_sync;
    jtl_state_t        state;
    logic [1:0]        mf_cnt;
    logic [3:0][14:0]  scr;
    jtl_octets_t       ch_dat;
    logic [3:0]        ch_k;
  } jtl_main_st_t;

  jtl_main_st_t q;
  jtl_main_st_t n;

  logic        sysref_pulse;
  logic [4:0]  lmfc_cnt;
  logic        mf_start;
  logic        frame_last;
  logic        wb_req;
  logic [5:0]  reg_idx;
  logic [7:0]  wbyte;
  jtl_octets_t chan_in;
  jtl_octets_t lane_dat;

  // self-synchronous scrambler, polynomial 1 + x^14 + x^15, msb first
  function automatic logic [22:0] jtl_scramble(
    input logic [14:0] st,
    input logic [7:0]  d
  );
    logic [14:0] s;
    logic [7:0]  o;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[13] ^ s[14];
      s    = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction : jtl_scramble

  // fills every lane of a group with one octet
  function automatic jtl_octets_t jtl_fill(input logic [7:0] v);
    jtl_octets_t r;
    for (int l = 0; l < 4; l++)
    begin
      r[l] = v;
    end
    return r;
  endfunction : jtl_fill

  assign sysref_pulse = q.sysref_sync & ~q.sysref_prev;
  assign wb_req       = wb_cyc_i & wb_stb_i & ~q.ack;
  assign reg_idx      = wb_adr_i[7:2];
  assign wbyte        = wb_dat_i[7:0];
  assign chan_in      = {chan_d_i, chan_c_i, chan_b_i, chan_a_i};

  always_comb
  begin
    logic [22:0] sr;
    sr = 23'h0;
    n  = q;

    // pin inputs through two flip-flops
    n.sysref_meta = sysref_i;
    n.sysref_sync = q.sysref_meta;
    n.sysref_prev = q.sysref_sync;
    n.sync_n_meta = sync_n_i;
    n.sync_n_sync = q.sync_n_meta;

    // wishbone classic slave, one wait state, unmapped reads zero
    n.ack = wb_req;
    if (wb_req && !wb_we_i)
    begin
      unique case (reg_idx)
        `JTL_IDX_MF_SETUP:
          n.rdat = {q.counter_preset_enable, q.counter_start_value,
                    q.alignment_seq_delay};
        `JTL_IDX_SCR_CTRL:
          n.rdat = {q.scramble_enable, 7'h00};
        `JTL_IDX_MF_LEN:
          n.rdat = {3'h0, q.frames_field};
        `JTL_IDX_LANE_SWAP:
          n.rdat = q.lane_select;
        `JTL_IDX_POLARITY:
          n.rdat = {4'h0, q.polarity_flip};
        `JTL_IDX_STATUS:
          n.rdat = {q.state == JTL_DATA, q.state == JTL_ILA,
                    q.state == JTL_CGS, lmfc_cnt};
        default:
          n.rdat = `JTL_RST_BYTE;
      endcase
    end
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      unique case (reg_idx)
        `JTL_IDX_MF_SETUP:
        begin
          n.counter_preset_enable = wbyte[`JTL_PRESET_BIT]; // R1
          n.counter_start_value =
            wbyte[`JTL_START_HI:`JTL_START_LO]; // R4
          n.alignment_seq_delay =
            wbyte[`JTL_DELAY_HI:`JTL_DELAY_LO];
        end
        `JTL_IDX_SCR_CTRL:
          n.scramble_enable = wbyte[`JTL_SCR_BIT];
        `JTL_IDX_MF_LEN:
          n.frames_field = wbyte[`JTL_K_HI:`JTL_K_LO];
        `JTL_IDX_LANE_SWAP:
          n.lane_select = wbyte;
        `JTL_IDX_POLARITY:
          n.polarity_flip = wbyte[`JTL_POL_HI:`JTL_POL_LO];
        default:
          n.lane_select = q.lane_select;
      endcase
    end

    // link sequencing; octets go to the lane map one cycle later
    n.ch_dat = jtl_fill(`JTL_K28_5);
    n.ch_k   = 4'hF;
    unique case (q.state)
      JTL_CGS:
      begin
        if (q.sync_n_sync)
          n.state = JTL_WAIT_LMFC;
      end
      JTL_WAIT_LMFC:
      begin
        if (lmfc_cnt == `JTL_LMFC_LAST)
        begin
          n.state  = JTL_DELAY; // R3
          n.mf_cnt = 2'h0;
        end
      end
      JTL_DELAY:
      begin
        n.ch_dat = jtl_fill(`JTL_FILL); // R3
        n.ch_k   = 4'h0;
        if (mf_start)
        begin
          if (q.mf_cnt == q.alignment_seq_delay)
          begin
            n.state  = JTL_ILA; // R5
            n.mf_cnt = 2'h0;
            n.ch_dat = jtl_fill(`JTL_K28_0);
            n.ch_k   = 4'hF;
          end
          else
            n.mf_cnt = q.mf_cnt + 2'h1; // R5
        end
      end
      JTL_ILA:
      begin
        n.ch_dat = jtl_fill(`JTL_FILL);
        n.ch_k   = 4'h0;
        if (frame_last)
        begin
          n.ch_dat = jtl_fill(`JTL_K28_3);
          n.ch_k   = 4'hF;
        end
        if (mf_start)
        begin
          if (q.mf_cnt == `JTL_ILA_LAST)
            n.state = JTL_DATA;
          else
          begin
            n.mf_cnt = q.mf_cnt + 2'h1;
            n.ch_dat = jtl_fill(`JTL_K28_0);
            n.ch_k   = 4'hF;
          end
        end
      end
      JTL_DATA:
      begin
        n.ch_k = 4'h0;
        for (int c = 0; c < 4; c++)
        begin
          sr = jtl_scramble(q.scr[c], chan_in[c]);
          if (q.scramble_enable)
          begin
            n.ch_dat[c] = sr[7:0]; // R6
            n.scr[c]    = sr[22:8];
          end
          else
            n.ch_dat[c] = chan_in[c]; // R6
        end
      end
    endcase

    // a receiver sync request restarts group synchronisation
    if (!q.sync_n_sync)
    begin
      n.state  = JTL_CGS;
      n.mf_cnt = 2'h0;
      n.ch_dat = jtl_fill(`JTL_K28_5);
      n.ch_k   = 4'hF;
      for (int c = 0; c < 4; c++)
      begin
        n.scr[c] = `JTL_RST_SCR;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q       <= '0; // R16
      q.state <= JTL_CGS;
    end
    else
      q <= n;
  end

  jtl_lmfc u_lmfc (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .sysref_i     (sysref_pulse),
    .preset_en_i  (q.counter_preset_enable),
    .start_val_i  (q.counter_start_value),
    .k_field_i    (q.frames_field),
    .lmfc_cnt_o   (lmfc_cnt),
    .mf_start_o   (mf_start),
    .frame_last_o (frame_last)
  );

  jtl_lane_map u_lane_map (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ch_dat_i   (q.ch_dat),
    .ch_k_i     (q.ch_k),
    .lane_sel_i (q.lane_select),
    .pol_i      (q.polarity_flip),
    .lane_dat_o (lane_dat),
    .lane_k_o   (lane_k_o),
    .lane_inv_o (lane_inv_o)
  );

  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = {24'h000000, q.rdat};
  assign lane_one_o   = lane_dat[0];
  assign lane_two_o   = lane_dat[1];
  assign lane_three_o = lane_dat[2];
  assign lane_four_o  = lane_dat[3];

endmodule : jtl_link_cfg
`default_nettype wire

// [sim/jtl_link_cfg_chk.sv]
// port assertions for the link configuration block
`timescale 1ns/1ns
`default_nettype none
module jtl_link_cfg_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sync_n_i,
  input wire logic [7:0]  lane_one_o,
  input wire logic [3:0]  lane_k_o,
  input wire logic [3:0]  lane_inv_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since the last acked write
  logic [3:0] age_q;
  always_ff @(posedge clk_i)
    if (rst_i || (wb_ack_o && wb_we_i))
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  chk_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
    else $error("ack without request");
  chk_read_upper:
    assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_cgs_comma:
    assert property (!sync_n_i [*8] |-> lane_k_o == 4'hF
                     && lane_one_o == 8'hBC)
    else $error("no comma during sync request");
  chk_lanes_aligned:
    assert property (lane_k_o == 4'h0 || lane_k_o == 4'hF)
    else $error("lanes disagree on control octets");
  chk_k_codes:
    assert property (lane_k_o[0] |-> lane_one_o inside {8'hBC, 8'h1C, 8'h7C})
    else $error("bad control octet");
  chk_inv_cause:
    assert property ($changed(lane_inv_o) |-> age_q < 4'h4)
    else $error("polarity changed without write");
  chk_reset_quiet:
    assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
                     && lane_inv_o == 4'h0)
    else $error("outputs not cleared by reset");
  cover property (lane_k_o[0] && lane_one_o == 8'h1C);
  cover property (lane_inv_o == 4'hF);
  cover property (wb_ack_o && !wb_we_i);
endmodule : jtl_link_cfg_chk
bind jtl_link_cfg jtl_link_cfg_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sync_n_i(sync_n_i), .lane_one_o(lane_one_o), .lane_k_o(lane_k_o),
  .lane_inv_o(lane_inv_o));
`default_nettype wire

// [sim/jtl_rx_model.sv]
// receiver model: raises sync after a run of comma octets
`timescale 1ns/1ns
`default_nettype none
module jtl_rx_model #(
  parameter int CGS_RUN = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       hold_i,
  input  wire logic [3:0] lane_k_i,
  input  wire logic [7:0] lane_one_i,
  output logic            sync_n_o
);
  logic [3:0] run_q;
  always_ff @(posedge clk_i)
    if (rst_i || hold_i)
    begin
      run_q    <= 4'h0;
      sync_n_o <= 1'b0;
    end
    else if (!sync_n_o)
    begin
      run_q    <= (lane_k_i == 4'hF && lane_one_i == 8'hBC) ? run_q + 4'h1
                                                            : 4'h0;
      sync_n_o <= (run_q == 4'(CGS_RUN));
    end
endmodule : jtl_rx_model
`default_nettype wire

// [sim/jtl_link_cfg_bench.sv]
// self-checking bench for the link configuration block
`timescale 1ns/1ns
`default_nettype none
module jtl_link_cfg_bench;
  import jtl_pkg::*;
  logic            clk_i, rst_i, cyc, stb, we, sysref, hold, sync_n, ack;
  logic [7:0]      adr, l1, l2, l3, l4;
  logic [31:0]     wdat, rdat;
  logic [3:0]      sel, lane_k, inv;
  logic [3:0][7:0] ch;
  int              miscompares, compares;
  logic [7:0] ra [5] = '{8'h0C, 8'h14, 8'h18, 8'h84, 8'h88};
  logic [7:0] rv [5] = '{8'hD3, 8'h80, 8'h0F, 8'hA0, 8'h03};
  logic [7:0] sv [4] = '{8'h00, 8'hA0, 8'h0A, 8'hAA};
  logic [7:0] pv [4] = '{8'h00, 8'h0C, 8'h03, 8'h0F};
  jtl_link_cfg i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sysref_i(sysref), .sync_n_i(sync_n),
    .chan_a_i(ch[0]), .chan_b_i(ch[1]), .chan_c_i(ch[2]), .chan_d_i(ch[3]),
    .lane_one_o(l1), .lane_two_o(l2), .lane_three_o(l3), .lane_four_o(l4),
    .lane_k_o(lane_k), .lane_inv_o(inv));
  jtl_rx_model i_rx (
    .clk_i(clk_i), .rst_i(rst_i), .hold_i(hold), .lane_k_i(lane_k),
    .lane_one_i(l1), .sync_n_o(sync_n));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic tally_and_finish();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, 24'h0, d, 4'hF};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_i);
  endtask : xfer
  task automatic run_link(input logic [7:0] setup, output int c,
                          output int i, output int e);
    logic [31:0] r;
    xfer(1'b1, 8'h0C, setup, r);
    hold <= 1'b1;
    repeat (8) @(posedge clk_i);
    hold <= 1'b0;
    @(posedge clk_i);
    sysref <= 1'b1;
    @(posedge clk_i);
    sysref <= 1'b0;
    c = -1;
    i = -1;
    e = -1;
    for (int n = 0; n < 400 && e < 0; n++)
    begin
      @(posedge clk_i);
      // first octet that is no longer K28.5
      if (c < 0 && !(lane_k === 4'hF && l1 === 8'hBC)) c = n;
      if (i < 0 && lane_k === 4'hF && l1 === 8'h1C) i = n;
      if (i >= 0 && e < 0 && lane_k === 4'hF && l1 === 8'h7C) e = n;
    end
    repeat (140) @(posedge clk_i);
  endtask : run_link
  initial
  begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] r, ex;
    logic [3:0]  ei;
    int          c0, i0, e0, c, i, e, l, nd;
    {cyc, stb, we, sysref, adr, wdat, sel, ch} = '0;
    hold = 1'b1;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      foreach (ra[k])
      begin
        xfer(1'b0, ra[k], 8'h00, r);
        chk(r, 32'h0);
      end
      // legal select and polarity codes only, four-lane link
      for (int k = 0; k < 5 && p == 0; k++)
      begin
        xfer(1'b1, ra[k], rv[k], r);
        xfer(1'b0, ra[k], 8'h00, r);
        chk(r, {24'h0, rv[k]});
      end
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
    end
    xfer(1'b0, 8'hFC, 8'h00, r);
    chk(r, 32'h0);
    xfer(1'b1, 8'h18, 8'h1F, r);
    run_link(8'h00, c0, i0, e0);
    chk(32'(e0 - i0), 32'd31);
    run_link(8'h50, c, i, e);
    chk(32'(c), 32'(c0));
    run_link(8'hD0, c, i, e);
    chk(32'(c0 - c), 32'd20);
    for (int d = 1; d < 4; d++)
    begin
      run_link(8'(d), c, i, e);
      chk(32'((i - c) - (i0 - c0)), 32'(32 * d));
    end
    xfer(1'b1, 8'h18, 8'h03, r);
    run_link(8'h00, c, i, e);
    chk(32'(e - i), 32'd3);
    // status: link in data phase, count bits masked
    xfer(1'b0, 8'h90, 8'h00, r);
    chk(r & 32'hFFFFFFE0, 32'h00000080);
    for (int k = 0; k < 4; k++)
    begin
      for (int h = 0; h < 4; h++)
        ch[h] <= 8'(16 * h + k + 1);
      xfer(1'b1, 8'h84, sv[k], r);
      xfer(1'b1, 8'h88, pv[k], r);
      repeat (6) @(posedge clk_i);
      for (int h = 0; h < 4; h++)
      begin
        l = (sv[k][7 - 2 * h -: 2] == 2'b10) ? (h ^ 1) : h;
        ex[8 * l +: 8] = 8'(16 * h + k + 1);
        ei[l] = pv[k][3 - h];
      end
      chk({l4, l3, l2, l1}, ex);
      chk({28'h0, inv}, {28'h0, ei});
    end
    xfer(1'b1, 8'h14, 8'h80, r);
    repeat (3) @(posedge clk_i);
    nd = 0;
    repeat (8)
    begin
      @(posedge clk_i);
      if (l1 !== ex[7:0]) nd++;
    end
    chk(32'(nd != 0), 32'h1);
    xfer(1'b1, 8'h14, 8'h00, r);
    repeat (6) @(posedge clk_i);
    chk({l4, l3, l2, l1}, ex);
    tally_and_finish();
  end
endmodule : jtl_link_cfg_bench
`default_nettype wire
